/* File: design/agu_pkg.sv */
// agu_pkg: constants and enumerations of the dual data space address unit.
// assumes: 16-bit byte addressed data space, one core clock.
`default_nettype none
package agu_pkg;

  // address and data widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // space layout defaults (boundaries are parameters of the top module)
  localparam logic [15:0] Y_BASE_DEF = 16'h0c00;
  localparam logic [15:0] Y_END_DEF = 16'h0fff;
  localparam logic [15:0] PHYS_END_DEF = 16'h0fff;
  localparam logic [15:0] NEAR_MASK = 16'h1fff;
  localparam logic [15:0] SFR_TOP = 16'h0800;

  // post-modify steps and alignment
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] EVEN_MASK = 16'hfffe;

  // values after reset
  localparam logic [15:0] RST_PTR = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h0800;

  // byte lane strobes
  localparam logic [1:0] BE_NONE = 2'h0;
  localparam logic [1:0] BE_LO = 2'h1;
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [1:0] BE_WORD = 2'h3;

  // access kinds issued by the pipeline
  typedef enum logic [2:0] {
    OP_INDIRECT = 3'h0,
    OP_NEAR = 3'h1,
    OP_FULL = 3'h2,
    OP_MAC = 3'h3,
    OP_ACC_WB = 3'h4,
    OP_PUSH = 3'h5,
    OP_POP = 3'h6
  } op_e;

  // what a push carries
  typedef enum logic [1:0] {
    PUSH_DATA = 2'h0,
    PUSH_PC_CALL = 2'h1,
    PUSH_PC_EXC = 2'h2
  } push_e;

  // pointer registers reachable by the pipeline
  typedef enum logic [2:0] {
    PTR_XA = 3'h0,
    PTR_XB = 3'h1,
    PTR_YA = 3'h2,
    PTR_YB = 3'h3,
    PTR_SP = 3'h4,
    PTR_STACK_LIMIT_REG = 3'h5
  } ptr_e;

endpackage : agu_pkg
`default_nettype wire

/* File: design/agu_step_if.sv */
// agu_step_if: carries one pointer post-modify request and its result.
// assumes: driven combinationally by the agu top, answered by agu_ptr_step.
`timescale 1ns/1ps
`default_nettype none
interface agu_step_if;
  logic [15:0] ptr;
  logic size_byte;
  logic mod_en;
  logic [15:0] mod_start;
  logic [15:0] mod_end;
  logic rev_en;
  logic [15:0] rev_mod;
  logic [15:0] nxt;

  // the side asking for a step
  modport user (output ptr, size_byte, mod_en, mod_start, mod_end, rev_en, rev_mod,
    input nxt);
  // the stepping logic
  modport stepper (input ptr, size_byte, mod_en, mod_start, mod_end, rev_en, rev_mod,
    output nxt);
endinterface : agu_step_if
`default_nettype wire

/* File: design/agu_ptr_step.sv */
// agu_ptr_step: post-increment of one pointer, scaled by size, with modulo
// wrap or bit-reversed carry. assumes: purely combinational use.
`timescale 1ns/1ps
`default_nettype none
module agu_ptr_step (
  // step request and result
  agu_step_if.stepper s
);

  // reverse bit order of a 16-bit word
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : rev16

  logic [15:0] sum;

  // byte steps by one, word by two; wrap at buffer end or reverse-carry add
  always_comb begin
    sum = s.ptr + (s.size_byte ? agu_pkg::STEP_BYTE : agu_pkg::STEP_WORD);
    if (s.rev_en) begin
      s.nxt = rev16(rev16(s.ptr) + rev16(s.rev_mod));
    end else if (s.mod_en && (sum > s.mod_end)) begin
      s.nxt = s.mod_start;
    end else begin
      s.nxt = sum;
    end
  end

endmodule : agu_ptr_step
`default_nettype wire

/* File: design/dual_data_space_agu.sv */
// dual_data_space_agu: address generation for split X/Y data spaces, byte
// lanes, alignment and stack checks. assumes: data memory reads are
// combinational on the presented address; pipeline issues one access a cycle.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - MAC reads Y, X via own pointers
// - non-MAC: whole space is linear X
// - MAC X reads exclude the Y block
// - writes only on X bus; Y read-only
// - accumulator write back may target any address
// - modulo on X, Y; bit-reverse indirect X writes
// - unimplemented address reads return zero
// - MAC cross-space pointer reads return zero
// - 16-bit byte addresses, 16-bit words
// - byte read selects lane by bit 0
// - Y path fetches whole words only
// - byte write strobes only matching lane
// - post-increment one for byte, two word
// - odd word access traps; write suppressed
// - byte loads change register low byte only
// - near direct field maps to 0x0000-0x1fff
// - 16-bit direct field reaches whole X
// - stack grows up, push post-inc, pop pre-dec
// - call push zeroes high byte; exception adds status
// - stack limit bit 0 zero, no reset
// - push above stack limit traps
// - stack address below 0x0800 traps
module dual_data_space_agu #(
  parameter logic [15:0] Y_BASE = agu_pkg::Y_BASE_DEF,
  parameter logic [15:0] Y_END = agu_pkg::Y_END_DEF,
  parameter logic [15:0] PHYS_END = agu_pkg::PHYS_END_DEF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // access request from the pipeline
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_op,
  input wire logic i_req_write,
  input wire logic i_req_byte,
  input wire logic [15:0] i_req_ea,
  input wire logic [15:0] i_req_wdata,
  input wire logic [1:0] i_req_push_kind,
  input wire logic [7:0] i_status_low,
  input wire logic i_req_xsel,
  input wire logic i_req_ysel,
  input wire logic i_req_xpost,
  input wire logic i_req_ypost,
  // addressing mode settings
  input wire logic i_xmod_en,
  input wire logic [15:0] i_xmod_start,
  input wire logic [15:0] i_xmod_end,
  input wire logic i_ymod_en,
  input wire logic [15:0] i_ymod_start,
  input wire logic [15:0] i_ymod_end,
  input wire logic i_bitrev_en,
  input wire logic [15:0] i_bitrev_mod,
  // pointer register writes
  input wire logic i_ptr_wr,
  input wire logic [2:0] i_ptr_idx,
  input wire logic [15:0] i_ptr_data,
  // X data memory
  output logic o_x_rd,
  output logic [15:0] o_x_raddr,
  input wire logic [15:0] i_x_rdata,
  output logic [1:0] o_x_we,
  output logic [15:0] o_x_waddr,
  output logic [15:0] o_x_wdata,
  // Y data memory (read only)
  output logic o_y_rd,
  output logic [15:0] o_y_raddr,
  input wire logic [15:0] i_y_rdata,
  // response to the pipeline
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_xdata,
  output logic [15:0] o_rsp_ydata,
  output logic [1:0] o_rsp_wreg_be,
  output logic [15:0] o_rsp_ea_next,
  // trap requests
  output logic o_addr_err,
  output logic o_stack_err,
  // pointer state
  output logic [15:0] o_x_pointer_a,
  output logic [15:0] o_x_pointer_b,
  output logic [15:0] o_y_pointer_a,
  output logic [15:0] o_y_pointer_b,
  output logic [15:0] o_stack_pointer,
  output logic [15:0] o_stack_limit
);

  agu_pkg::op_e op;
  logic is_mac, is_stack, is_wr, is_rd, byte_eff, mis, x_zero, y_zero, stk_bad;
  logic [15:0] ea, y_ea, wdata;
  logic [1:0] be;

  // pointer registers
  logic [15:0] xa_r, xb_r, ya_r, yb_r, sp_r, stack_limit_reg_r;
  logic [15:0] xa_nxt, xb_nxt, ya_nxt, yb_nxt, sp_nxt, stack_limit_reg_nxt;
  // stage 1: memory access
  logic x_rd_r, y_rd_r, byte1_r, lo1_r, xz1_r, yz1_r, v1_r, aerr_r, serr_r;
  logic [15:0] x_raddr_r, y_raddr_r, x_waddr_r, x_wdata_r, next1_r;
  logic [1:0] x_we_r, wbe1_r;
  logic x_rd_nxt, y_rd_nxt, byte1_nxt, lo1_nxt, xz1_nxt, yz1_nxt, v1_nxt;
  logic aerr_nxt, serr_nxt;
  logic [15:0] x_raddr_nxt, y_raddr_nxt, x_waddr_nxt, x_wdata_nxt, next1_nxt;
  logic [1:0] x_we_nxt, wbe1_nxt;
  // stage 2: response
  logic rsp_v_r;
  logic [15:0] rsp_x_r, rsp_y_r, rsp_next_r;
  logic [1:0] rsp_be_r;
  logic rsp_v_nxt;
  logic [15:0] rsp_x_nxt, rsp_y_nxt, rsp_next_nxt;
  logic [1:0] rsp_be_nxt;

  agu_step_if gen_if ();
  agu_step_if xs_if ();
  agu_step_if ys_if ();

  // pointer steppers: generic X pointer, MAC X pointer, MAC Y pointer
  agu_ptr_step u_gen_step (.s(gen_if.stepper));
  agu_ptr_step u_x_step (.s(xs_if.stepper));
  agu_ptr_step u_y_step (.s(ys_if.stepper));

  assign op = agu_pkg::op_e'(i_req_op);
  assign is_mac = (op == agu_pkg::OP_MAC);
  assign is_stack = (op == agu_pkg::OP_PUSH) || (op == agu_pkg::OP_POP);

  // effective address by access kind
  always_comb begin
    case (op)
      agu_pkg::OP_NEAR: ea = i_req_ea & agu_pkg::NEAR_MASK;
      agu_pkg::OP_FULL: ea = i_req_ea;
      agu_pkg::OP_MAC: ea = i_req_xsel ? xb_r : xa_r;
      agu_pkg::OP_PUSH: ea = sp_r;
      agu_pkg::OP_POP: ea = sp_r - agu_pkg::STEP_WORD;
      default: ea = i_req_ea;
    endcase
  end
  assign y_ea = i_req_ysel ? yb_r : ya_r;

  // access class, size and validity checks
  assign is_wr = ((op == agu_pkg::OP_INDIRECT || op == agu_pkg::OP_NEAR ||
    op == agu_pkg::OP_FULL) && i_req_write) || op == agu_pkg::OP_ACC_WB ||
    op == agu_pkg::OP_PUSH;
  assign is_rd = !is_wr;
  assign byte_eff = i_req_byte && !is_mac && !is_stack && op != agu_pkg::OP_ACC_WB;
  assign mis = !byte_eff && ea[0];
  // MAC X reads exclude the Y block; otherwise the space is one linear X
  assign x_zero = (ea > PHYS_END) || (is_mac && ea >= Y_BASE && ea <= Y_END);
  assign y_zero = (y_ea > PHYS_END) || y_ea < Y_BASE || y_ea > Y_END;
  assign stk_bad = is_stack && ((op == agu_pkg::OP_PUSH && ea > stack_limit_reg_r) ||
    ea < agu_pkg::SFR_TOP);
  assign be = byte_eff ? (ea[0] ? agu_pkg::BE_HI : agu_pkg::BE_LO) : agu_pkg::BE_WORD;

  // write data: byte replicated to both lanes, PC high byte push composition
  always_comb begin
    if (op == agu_pkg::OP_PUSH && i_req_push_kind == agu_pkg::PUSH_PC_CALL) begin
      wdata = {8'h00, i_req_wdata[7:0]};
    end else if (op == agu_pkg::OP_PUSH && i_req_push_kind == agu_pkg::PUSH_PC_EXC) begin
      wdata = {i_status_low, i_req_wdata[7:0]};
    end else if (byte_eff) begin
      wdata = {i_req_wdata[7:0], i_req_wdata[7:0]};
    end else begin
      wdata = i_req_wdata;
    end
  end

  // step requests; bit-reverse only for indirect writes into X
  assign gen_if.ptr = ea;
  assign gen_if.size_byte = byte_eff;
  assign gen_if.mod_en = i_xmod_en;
  assign gen_if.mod_start = i_xmod_start;
  assign gen_if.mod_end = i_xmod_end;
  assign gen_if.rev_en = i_bitrev_en && is_wr && op == agu_pkg::OP_INDIRECT;
  assign gen_if.rev_mod = i_bitrev_mod;
  assign xs_if.ptr = ea;
  assign xs_if.size_byte = 1'b0;
  assign xs_if.mod_en = i_xmod_en;
  assign xs_if.mod_start = i_xmod_start;
  assign xs_if.mod_end = i_xmod_end;
  assign xs_if.rev_en = 1'b0;
  assign xs_if.rev_mod = i_bitrev_mod;
  assign ys_if.ptr = y_ea;
  assign ys_if.size_byte = 1'b0;
  assign ys_if.mod_en = i_ymod_en;
  assign ys_if.mod_start = i_ymod_start;
  assign ys_if.mod_end = i_ymod_end;
  assign ys_if.rev_en = 1'b0;
  assign ys_if.rev_mod = i_bitrev_mod;

  // pointer updates; a pipeline write to a pointer overrides a step
  always_comb begin
    xa_nxt = xa_r;
    xb_nxt = xb_r;
    ya_nxt = ya_r;
    yb_nxt = yb_r;
    sp_nxt = sp_r;
    stack_limit_reg_nxt = stack_limit_reg_r;
    if (i_req_valid && is_mac && i_req_xpost) begin
      if (i_req_xsel) xb_nxt = xs_if.nxt;
      else xa_nxt = xs_if.nxt;
    end
    if (i_req_valid && is_mac && i_req_ypost) begin
      if (i_req_ysel) yb_nxt = ys_if.nxt;
      else ya_nxt = ys_if.nxt;
    end
    if (i_req_valid && op == agu_pkg::OP_PUSH) sp_nxt = sp_r + agu_pkg::STEP_WORD;
    if (i_req_valid && op == agu_pkg::OP_POP) sp_nxt = ea;
    if (i_ptr_wr) begin
      case (agu_pkg::ptr_e'(i_ptr_idx))
        agu_pkg::PTR_XA: xa_nxt = i_ptr_data;
        agu_pkg::PTR_XB: xb_nxt = i_ptr_data;
        agu_pkg::PTR_YA: ya_nxt = i_ptr_data;
        agu_pkg::PTR_YB: yb_nxt = i_ptr_data;
        agu_pkg::PTR_SP: sp_nxt = i_ptr_data & agu_pkg::EVEN_MASK;
        agu_pkg::PTR_STACK_LIMIT_REG: stack_limit_reg_nxt = i_ptr_data & agu_pkg::EVEN_MASK;
        default: stack_limit_reg_nxt = stack_limit_reg_r; // unused index must not undo a step
      endcase
    end
  end

  // pointer registers with reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      xa_r <= agu_pkg::RST_PTR;
      xb_r <= agu_pkg::RST_PTR;
      ya_r <= agu_pkg::RST_PTR;
      yb_r <= agu_pkg::RST_PTR;
      sp_r <= agu_pkg::RST_SP;
    end else begin
      xa_r <= xa_nxt;
      xb_r <= xb_nxt;
      ya_r <= ya_nxt;
      yb_r <= yb_nxt;
      sp_r <= sp_nxt;
    end
  end

  // stack limit keeps its value through reset
  always_ff @(posedge i_clk) begin
    stack_limit_reg_r <= stack_limit_reg_nxt;
  end

  // stage 1: drive memory, raise traps
  always_comb begin
    v1_nxt = i_req_valid;
    x_rd_nxt = i_req_valid && is_rd && !x_zero;
    x_raddr_nxt = ea & agu_pkg::EVEN_MASK;
    y_rd_nxt = i_req_valid && is_mac && !y_zero;
    y_raddr_nxt = y_ea & agu_pkg::EVEN_MASK;
    // misaligned or unimplemented writes are dropped
    x_we_nxt = (i_req_valid && is_wr && !mis && ea <= PHYS_END) ? be : agu_pkg::BE_NONE;
    x_waddr_nxt = ea & agu_pkg::EVEN_MASK;
    x_wdata_nxt = wdata;
    byte1_nxt = byte_eff;
    lo1_nxt = ea[0];
    xz1_nxt = x_zero || is_wr;
    yz1_nxt = y_zero || !is_mac;
    wbe1_nxt = (is_rd && !is_mac) ? (byte_eff ? agu_pkg::BE_LO : agu_pkg::BE_WORD)
      : agu_pkg::BE_NONE;
    next1_nxt = gen_if.nxt;
    aerr_nxt = i_req_valid && mis;
    serr_nxt = i_req_valid && stk_bad;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      v1_r <= 1'b0;
      x_rd_r <= 1'b0;
      x_raddr_r <= agu_pkg::RST_PTR;
      y_rd_r <= 1'b0;
      y_raddr_r <= agu_pkg::RST_PTR;
      x_we_r <= agu_pkg::BE_NONE;
      x_waddr_r <= agu_pkg::RST_PTR;
      x_wdata_r <= agu_pkg::RST_PTR;
      byte1_r <= 1'b0;
      lo1_r <= 1'b0;
      xz1_r <= 1'b1;
      yz1_r <= 1'b1;
      wbe1_r <= agu_pkg::BE_NONE;
      next1_r <= agu_pkg::RST_PTR;
      aerr_r <= 1'b0;
      serr_r <= 1'b0;
    end else begin
      v1_r <= v1_nxt;
      x_rd_r <= x_rd_nxt;
      x_raddr_r <= x_raddr_nxt;
      y_rd_r <= y_rd_nxt;
      y_raddr_r <= y_raddr_nxt;
      x_we_r <= x_we_nxt;
      x_waddr_r <= x_waddr_nxt;
      x_wdata_r <= x_wdata_nxt;
      byte1_r <= byte1_nxt;
      lo1_r <= lo1_nxt;
      xz1_r <= xz1_nxt;
      yz1_r <= yz1_nxt;
      wbe1_r <= wbe1_nxt;
      next1_r <= next1_nxt;
      aerr_r <= aerr_nxt;
      serr_r <= serr_nxt;
    end
  end

  // stage 2: lane select, zero return, response
  always_comb begin
    rsp_v_nxt = v1_r;
    if (xz1_r) rsp_x_nxt = 16'h0000;
    else if (byte1_r) rsp_x_nxt = {8'h00, lo1_r ? i_x_rdata[15:8] : i_x_rdata[7:0]};
    else rsp_x_nxt = i_x_rdata;
    rsp_y_nxt = yz1_r ? 16'h0000 : i_y_rdata;
    rsp_be_nxt = wbe1_r;
    rsp_next_nxt = next1_r;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rsp_v_r <= 1'b0;
      rsp_x_r <= 16'h0000;
      rsp_y_r <= 16'h0000;
      rsp_be_r <= agu_pkg::BE_NONE;
      rsp_next_r <= agu_pkg::RST_PTR;
    end else begin
      rsp_v_r <= rsp_v_nxt;
      rsp_x_r <= rsp_x_nxt;
      rsp_y_r <= rsp_y_nxt;
      rsp_be_r <= rsp_be_nxt;
      rsp_next_r <= rsp_next_nxt;
    end
  end

  // outputs
  assign o_x_rd = x_rd_r;
  assign o_x_raddr = x_raddr_r;
  assign o_x_we = x_we_r;
  assign o_x_waddr = x_waddr_r;
  assign o_x_wdata = x_wdata_r;
  assign o_y_rd = y_rd_r;
  assign o_y_raddr = y_raddr_r;
  assign o_rsp_valid = rsp_v_r;
  assign o_rsp_xdata = rsp_x_r;
  assign o_rsp_ydata = rsp_y_r;
  assign o_rsp_wreg_be = rsp_be_r;
  assign o_rsp_ea_next = rsp_next_r;
  assign o_addr_err = aerr_r;
  assign o_stack_err = serr_r;
  assign o_x_pointer_a = xa_r;
  assign o_x_pointer_b = xb_r;
  assign o_y_pointer_a = ya_r;
  assign o_y_pointer_b = yb_r;
  assign o_stack_pointer = sp_r;
  assign o_stack_limit = stack_limit_reg_r;

endmodule : dual_data_space_agu
`default_nettype wire

/* File: bench/dual_data_space_agu_assertions.sv */
// checker: port timing relations of the dual data space address unit.
// assumes: bound into dual_data_space_agu, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dual_data_space_agu_assertions #(
  parameter logic [15:0] Y_BASE = 16'h0c00,
  parameter logic [15:0] Y_END = 16'h0fff,
  parameter logic [15:0] PHYS_END = 16'h0fff
) (
  // clock, reset and requests
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_op,
  input wire logic i_req_write,
  input wire logic i_req_byte,
  input wire logic [15:0] i_req_ea,
  input wire logic [1:0] i_req_push_kind,
  input wire logic [7:0] i_status_low,
  input wire logic i_req_xsel,
  input wire logic i_xmod_en,
  input wire logic i_bitrev_en,
  input wire logic i_ptr_wr,
  input wire logic [2:0] i_ptr_idx,
  input wire logic [15:0] i_ptr_data,
  // outputs watched
  input wire logic o_y_rd,
  input wire logic [1:0] o_x_we,
  input wire logic [15:0] o_x_waddr,
  input wire logic [15:0] o_x_wdata,
  input wire logic [15:0] o_x_raddr,
  input wire logic o_rsp_valid,
  input wire logic [15:0] o_rsp_xdata,
  input wire logic [15:0] o_rsp_ea_next,
  input wire logic o_addr_err,
  input wire logic o_stack_err,
  input wire logic [15:0] o_x_pointer_b,
  input wire logic [15:0] o_stack_pointer,
  input wire logic [15:0] o_stack_limit
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // helper terms: request kinds and expected values
  wire logic ind = i_req_valid && i_req_op == 3'h0;
  wire logic push = i_req_valid && i_req_op == 3'h5 && !i_ptr_wr;
  wire logic pop = i_req_valid && i_req_op == 3'h6 && !i_ptr_wr;
  wire logic over = o_stack_pointer > o_stack_limit;
  wire logic [1:0] lane = i_req_ea[0] ? 2'h2 : 2'h1;
  wire logic [15:0] step = i_req_ea + (i_req_byte ? 16'h0001 : 16'h0002);
  wire logic [15:0] lim = i_ptr_data & 16'hfffe;
  property p_rsp; ind |-> ##2 o_rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no response two cycles on");
  property p_yrd; o_y_rd |-> $past(i_req_valid) && $past(i_req_op) == 3'h3; endproperty
  a_yrd: assert property (p_yrd) else $error("y read outside dual fetch");
  property p_lane;
    ind && i_req_write && i_req_byte && i_req_ea <= PHYS_END |=> o_x_we == $past(lane);
  endproperty
  a_lane: assert property (p_lane) else $error("wrong byte lane strobe");
  property p_odd;
    ind && !i_req_byte && i_req_ea[0] |=> o_addr_err && o_x_we == 2'h0;
  endproperty
  a_odd: assert property (p_odd) else $error("odd word access not trapped");
  property p_step;
    ind && !i_xmod_en && !i_bitrev_en |-> ##2 o_rsp_ea_next == $past(step, 2);
  endproperty
  a_step: assert property (p_step) else $error("post increment size wrong");
  property p_push;
    push |=> o_x_waddr == $past(o_stack_pointer) &&
      o_stack_pointer == $past(o_stack_pointer) + 16'h0002;
  endproperty
  a_push: assert property (p_push) else $error("push address or step wrong");
  property p_pop;
    pop |=> o_x_raddr == $past(o_stack_pointer) - 16'h0002 && o_stack_pointer == o_x_raddr;
  endproperty
  a_pop: assert property (p_pop) else $error("pop address or step wrong");
  property p_sfr; push && o_stack_pointer < 16'h0800 |=> o_stack_err; endproperty
  a_sfr: assert property (p_sfr) else $error("stack underflow not trapped");
  property p_lim; push && o_stack_pointer >= 16'h0800 |=> o_stack_err == $past(over); endproperty
  a_lim: assert property (p_lim) else $error("stack limit trap wrong");
  property p_call; push && i_req_push_kind == 2'h1 |=> o_x_wdata[15:8] == 8'h00; endproperty
  a_call: assert property (p_call) else $error("call push high byte not zero");
  property p_exc;
    push && i_req_push_kind == 2'h2 |=> o_x_wdata[15:8] == $past(i_status_low);
  endproperty
  a_exc: assert property (p_exc) else $error("exception push lacks status");
  property p_stack_limit_reg; i_ptr_wr && i_ptr_idx == 3'h5 |=> o_stack_limit == $past(lim); endproperty
  a_stack_limit_reg: assert property (p_stack_limit_reg) else $error("stack limit bit 0 not clear");
  property p_cross;
    i_req_valid && i_req_op == 3'h3 && i_req_xsel && o_x_pointer_b >= Y_BASE &&
      o_x_pointer_b <= Y_END |-> ##2 o_rsp_xdata == 16'h0000;
  endproperty
  a_cross: assert property (p_cross) else $error("cross space read not zero");
  // main scenarios reached
  c_trap: cover property (push ##1 o_stack_err);
  c_odd: cover property (o_addr_err);
  c_mac: cover property (o_y_rd ##1 o_rsp_valid);
endmodule : dual_data_space_agu_assertions
bind dual_data_space_agu dual_data_space_agu_assertions #(
  .Y_BASE(Y_BASE), .Y_END(Y_END), .PHYS_END(PHYS_END)
) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .i_req_op(i_req_op),
  .i_req_write(i_req_write), .i_req_byte(i_req_byte), .i_req_ea(i_req_ea),
  .i_req_push_kind(i_req_push_kind), .i_status_low(i_status_low), .i_req_xsel(i_req_xsel),
  .i_xmod_en(i_xmod_en), .i_bitrev_en(i_bitrev_en), .i_ptr_wr(i_ptr_wr),
  .i_ptr_idx(i_ptr_idx), .i_ptr_data(i_ptr_data), .o_y_rd(o_y_rd), .o_x_we(o_x_we),
  .o_x_waddr(o_x_waddr), .o_x_wdata(o_x_wdata), .o_x_raddr(o_x_raddr),
  .o_rsp_valid(o_rsp_valid), .o_rsp_xdata(o_rsp_xdata), .o_rsp_ea_next(o_rsp_ea_next),
  .o_addr_err(o_addr_err), .o_stack_err(o_stack_err), .o_x_pointer_b(o_x_pointer_b),
  .o_stack_pointer(o_stack_pointer), .o_stack_limit(o_stack_limit)
);
`default_nettype wire

/* File: bench/data_mem_model.sv */
// data_mem_model: combinational X/Y data memory with byte-lane writes.
// assumes: addresses within 0x0000-0x0fff; reads answer in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
  // clock
  input wire logic i_clk,
  // X port
  input wire logic i_x_rd,
  input wire logic [15:0] i_x_raddr,
  output logic [15:0] o_x_rdata,
  input wire logic [1:0] i_x_we,
  input wire logic [15:0] i_x_waddr,
  input wire logic [15:0] i_x_wdata,
  // Y port, read only
  input wire logic i_y_rd,
  input wire logic [15:0] i_y_raddr,
  output logic [15:0] o_y_rdata
);
  logic [15:0] mem [0:2047];
  logic [15:0] junk = 16'h5a5a;
  // lanes written apart, so a byte write keeps the other byte
  always @(posedge i_clk) begin
    junk <= ~junk;
    if (i_x_we[0]) mem[i_x_waddr[11:1]][7:0] <= i_x_wdata[7:0];
    if (i_x_we[1]) mem[i_x_waddr[11:1]][15:8] <= i_x_wdata[15:8];
  end
  // unselected ports show a toggling pattern, never stale data
  assign o_x_rdata = i_x_rd ? mem[i_x_raddr[11:1]] : junk;
  assign o_y_rdata = i_y_rd ? mem[i_y_raddr[11:1]] : ~junk;
endmodule : data_mem_model
`default_nettype wire

/* File: bench/dual_data_space_agu_tb_top.sv */
// testbench: drives pipeline requests at the falling edge, judges answers.
// assumes: answer timing of one cycle for strobes, two for responses.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module dual_data_space_agu_tb_top;
  logic clk, rst_n, valid, wr, byt, xsel, ysel, xpost, ypost, xm_en, ymod_en, bre, pwr;
  logic [2:0] op, pidx;
  logic [1:0] pk, we1, x_we, rsp_be, be;
  logic [7:0] stl;
  logic [15:0] ea, wdata, xms, xme, yms, yme, brm, pdata;
  logic x_rd, y_rd, rsp_v, aerr, serr, ae1, se1, xr1;
  logic [15:0] x_raddr, x_rdata, x_waddr, x_wdata, y_raddr, y_rdata, rsp_x, rsp_y, rsp_en;
  logic [15:0] xa, xb, ya, yb, sp, lim, wa1, wd1, ra1, xd, yd, en, yr1;
  int bad_count, checked;
  // clock of 5 ns period
  always #2.5 clk = ~clk;
  dual_data_space_agu DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_req_valid(valid), .i_req_op(op), .i_req_write(wr),
    .i_req_byte(byt), .i_req_ea(ea), .i_req_wdata(wdata), .i_req_push_kind(pk),
    .i_status_low(stl), .i_req_xsel(xsel), .i_req_ysel(ysel), .i_req_xpost(xpost),
    .i_req_ypost(ypost), .i_xmod_en(xm_en), .i_xmod_start(xms), .i_xmod_end(xme),
    .i_ymod_en(ymod_en), .i_ymod_start(yms), .i_ymod_end(yme), .i_bitrev_en(bre),
    .i_bitrev_mod(brm), .i_ptr_wr(pwr), .i_ptr_idx(pidx), .i_ptr_data(pdata),
    .o_x_rd(x_rd), .o_x_raddr(x_raddr), .i_x_rdata(x_rdata), .o_x_we(x_we),
    .o_x_waddr(x_waddr), .o_x_wdata(x_wdata), .o_y_rd(y_rd), .o_y_raddr(y_raddr),
    .i_y_rdata(y_rdata), .o_rsp_valid(rsp_v), .o_rsp_xdata(rsp_x), .o_rsp_ydata(rsp_y),
    .o_rsp_wreg_be(rsp_be), .o_rsp_ea_next(rsp_en), .o_addr_err(aerr), .o_stack_err(serr),
    .o_x_pointer_a(xa), .o_x_pointer_b(xb), .o_y_pointer_a(ya), .o_y_pointer_b(yb),
    .o_stack_pointer(sp), .o_stack_limit(lim)
  );
  data_mem_model mem (
    .i_clk(clk), .i_x_rd(x_rd), .i_x_raddr(x_raddr), .o_x_rdata(x_rdata), .i_x_we(x_we),
    .i_x_waddr(x_waddr), .i_x_wdata(x_wdata), .i_y_rd(y_rd), .i_y_raddr(y_raddr),
    .o_y_rdata(y_rdata)
  );
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // one request: capture strobes in cycle 1, response when it arrives
  task automatic req(input logic [2:0] o, input logic w, input logic b,
    input logic [15:0] a, input logic [15:0] d);
    int n;
    op = o; wr = w; byt = b; ea = a; wdata = d; valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    valid = 1'b0; we1 = x_we; wa1 = x_waddr; wd1 = x_wdata; ra1 = x_raddr;
    ae1 = aerr; se1 = serr; n = 0;
    xr1 = x_rd;
    yr1 = y_raddr;
    while (n < 4 && rsp_v !== 1'b1) begin
      @(posedge clk);
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, 1'b0, 1'b1);
      tally_and_finish;
    end
    xd = rsp_x; yd = rsp_y; be = rsp_be; en = rsp_en;
  endtask : req
  // pointer register load
  task automatic ptr(input logic [2:0] i, input logic [15:0] d);
    pidx = i; pdata = d; pwr = 1'b1;
    @(posedge clk);
    @(negedge clk);
    pwr = 1'b0;
    @(negedge clk);
  endtask : ptr
  task automatic t_bytes;
    req(3'h0, 1'b1, 1'b0, 16'h0100, 16'h5566);
    `CHK(we1, 2'h3)
    req(3'h0, 1'b1, 1'b1, 16'h0101, 16'h00ab);
    `CHK(we1, 2'h2)
    `CHK(wa1, 16'h0100)
    `CHK(en, 16'h0102)
    req(3'h0, 1'b0, 1'b0, 16'h0100, 16'h0000);
    `CHK(xd, 16'hab66)
    `CHK(xr1, 1'b1)
    `CHK(be, 2'h3)
    req(3'h0, 1'b0, 1'b1, 16'h0101, 16'h0000);
    `CHK(xd, 16'h00ab)
    `CHK(be, 2'h1)
    req(3'h1, 1'b0, 1'b1, 16'he100, 16'h0000);
    `CHK(xd, 16'h0066)
    req(3'h2, 1'b0, 1'b0, 16'h2000, 16'h0000);
    `CHK(xd, 16'h0000)
    `CHK(xr1, 1'b0)
    req(3'h0, 1'b1, 1'b0, 16'h0101, 16'hffff);
    `CHK(ae1, 1'b1)
    `CHK(we1, 2'h0)
    `CHK(se1, 1'b0)
    req(3'h0, 1'b0, 1'b0, 16'h0100, 16'h0000);
    `CHK(xd, 16'hab66)
    xm_en = 1'b1;
    xms = 16'h0100;
    xme = 16'h0103;
    req(3'h0, 1'b1, 1'b0, 16'h0102, 16'h0000);
    `CHK(en, 16'h0100)
    xm_en = 1'b0;
    bre = 1'b1;
    brm = 16'h0008;
    req(3'h0, 1'b1, 1'b0, 16'h0108, 16'h0000);
    `CHK(en, 16'h0104)
    bre = 1'b0;
    $display("t_bytes done");
  endtask : t_bytes
  task automatic t_mac;
    req(3'h0, 1'b1, 1'b0, 16'h0c02, 16'h7788);
    req(3'h2, 1'b0, 1'b0, 16'h0c02, 16'h0000);
    `CHK(xd, 16'h7788)
    ptr(3'h0, 16'h0100);
    ptr(3'h2, 16'h0c02);
    ymod_en = 1'b1; yms = 16'h0c02; yme = 16'h0c03;
    xsel = 1'b0; ysel = 1'b0; xpost = 1'b1; ypost = 1'b1;
    req(3'h3, 1'b0, 1'b0, 16'h0000, 16'h0000);
    `CHK(xd, 16'hab66)
    `CHK(yd, 16'h7788)
    `CHK(yr1, 16'h0c02)
    `CHK(be, 2'h0)
    `CHK(xa, 16'h0102)
    `CHK(ya, 16'h0c02)
    ptr(3'h1, 16'h0c02);
    ptr(3'h3, 16'h0100);
    `CHK(yb, 16'h0100)
    xsel = 1'b1; ysel = 1'b1; xpost = 1'b0; ypost = 1'b0;
    req(3'h3, 1'b0, 1'b0, 16'h0000, 16'h0000);
    `CHK(xd, 16'h0000)
    `CHK(yd, 16'h0000)
    req(3'h4, 1'b1, 1'b0, 16'h0c04, 16'h1357);
    `CHK(we1, 2'h3)
    `CHK(wa1, 16'h0c04)
    $display("t_mac done");
  endtask : t_mac
  task automatic t_stack;
    `CHK(sp, 16'h0800)
    ptr(3'h5, 16'h0803);
    `CHK(lim, 16'h0802)
    for (int i = 0; i < 3; i++) begin
      req(3'h5, 1'b0, 1'b0, 16'h0000, 16'h1110 + 16'(i));
      `CHK(wa1, 16'h0800 + 16'(2 * i))
      `CHK(se1, i == 2)
    end
    req(3'h6, 1'b0, 1'b0, 16'h0000, 16'h0000);
    `CHK(ra1, 16'h0804)
    `CHK(xd, 16'h1112)
    pk = 2'h1;
    req(3'h5, 1'b0, 1'b0, 16'h0000, 16'hee12);
    `CHK(wd1, 16'h0012)
    pk = 2'h2;
    req(3'h5, 1'b0, 1'b0, 16'h0000, 16'hee34);
    `CHK(wd1, 16'h5a34)
    pk = 2'h0;
    ptr(3'h4, 16'h07fe);
    req(3'h5, 1'b0, 1'b0, 16'h0000, 16'h0000);
    `CHK(se1, 1'b1)
    `CHK(ae1, 1'b0)
    $display("t_stack done");
  endtask : t_stack
  // reset, then the scenarios in turn
  initial begin
    clk = 1'b0; rst_n = 1'b0; valid = 1'b0; wr = 1'b0; byt = 1'b0; op = 3'h0;
    ea = 16'h0000; wdata = 16'h0000; pk = 2'h0; stl = 8'h5a; xsel = 1'b0; ysel = 1'b0;
    xpost = 1'b0; ypost = 1'b0; xm_en = 1'b0; xms = 16'h0000; xme = 16'h0000;
    ymod_en = 1'b0; yms = 16'h0000; yme = 16'h0000; bre = 1'b0; brm = 16'h0000;
    pwr = 1'b0; pidx = 3'h0; pdata = 16'h0000; bad_count = 0; checked = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_stack;
    t_bytes;
    t_mac;
    tally_and_finish;
  end
endmodule : dual_data_space_agu_tb_top
`default_nettype wire
